// [inc/switch_global_defines.vh]
// Register offsets, field positions, reset values and timing constants.
`ifndef SWITCH_GLOBAL_DEFINES_VH
`define SWITCH_GLOBAL_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_PRODUCT_LINE 8'h00
`define OFS_PART_START 8'h01
`define OFS_GLOBAL_CTRL0 8'h02

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_START 0
`define BIT_NEW_BACKOFF 7
`define BIT_PASS_FLOW 3
`define BIT_RSVD2 2
`define BIT_RSVD1 1
`define BIT_LINK_AGE 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_START 1'h1
`define RST_NEW_BACKOFF 1'h0
`define RST_PASS_FLOW 1'h0
`define RST_RSVD2 1'h1
`define RST_RSVD1 1'h0
`define RST_LINK_AGE 1'h0
`define GC0_FIXED_6_4 3'h4

// ----------------------------------------------------------------------
// Configuration memory layout
// ----------------------------------------------------------------------
`define EE_ADDR_FAMILY 8'h00
`define EE_ADDR_PART 8'h01
`define EE_ADDR_GC0 8'h02

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 8'hC8
`define US_CYCLES (`CLK_MHZ)
`define FAST_AGE_US 12'h320
`define FAST_AGE_PASS_US 28'h000031F
`define NORMAL_AGE_S 8'hC8
`define NORMAL_AGE_US 28'hBEBC200
`define EE_TIMEOUT_CYC 16'h0400

`endif

// [design/age_pacer.v]
// Address table age pacer with normal and fast aging periods.
`timescale 1ns/100ps
`include "switch_global_defines.vh"

module age_pacer #(
   parameter [7:0] US_CYC = `US_CYCLES,
   parameter [27:0] NORMAL_US = `NORMAL_AGE_US,
   parameter [27:0] FAST_US = `FAST_AGE_PASS_US
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire fast_req_i,
   output reg age_pass_o,
   output reg fast_active_o
);

   reg [7:0] pre_q;
   reg us_tick_q;
   reg [27:0] cnt_q;

   // Microsecond enable; keeps the long counters narrow.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         pre_q <= 8'h00;
         us_tick_q <= 1'b0;
      end else if (pre_q == US_CYC - 8'h01) begin
         pre_q <= 8'h00;
         us_tick_q <= 1'b1;
      end else begin
         pre_q <= pre_q + 8'h01;
         us_tick_q <= 1'b0;
      end
   end

   // A fast request restarts the period short; after that one pass the
   // pacer falls back to the normal period.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_q <= 28'h0000000;
         age_pass_o <= 1'b0;
         fast_active_o <= 1'b0;
      end else if (fast_req_i) begin
         cnt_q <= 28'h0000000;
         age_pass_o <= 1'b0;
         fast_active_o <= 1'b1; // (R9)
      end else if (us_tick_q) begin
         if (cnt_q >= (fast_active_o ? FAST_US : NORMAL_US) - 28'h1) begin
            cnt_q <= 28'h0000000;
            age_pass_o <= 1'b1;
            fast_active_o <= 1'b0; // (R9)
         end else begin
            cnt_q <= cnt_q + 28'h1;
            age_pass_o <= 1'b0;
         end
      end else begin
         age_pass_o <= 1'b0;
      end
   end

endmodule // age_pacer

// [design/switch_global_start_ctrl.v]
// Global identification, start-up gating and global control registers.
`timescale 1ns/100ps
`include "switch_global_defines.vh"

// Summary of operation
// (R1) Managed straps: run only while start is one.
// (R2) Managed straps: start zero holds switch stopped.
// (R3) Straps 00: run after configuration read ends.
// (R4) No memory answer: keep strap and built-in defaults.
// (R5) Override only when family and part codes match.
// (R6) Fixed codes read at offsets zero and one.
// (R7) Control bit 7 selects alternative back-off.
// (R8) Control bit 3 forwards flow control packets.
// (R9) Link drop with aging enabled: one fast pass.
// (R10) Any link drop flushes learned addresses.
// (R11) Software keeps reserved control fields at reset.
// (R12) Identification writes ignored; only start writable.
module switch_global_start_ctrl #(
   parameter [7:0] PRODUCT_LINE = 8'h5A, // Arbitrary value.
   parameter [3:0] PART_CODE = 4'h5, // Arbitrary value.
   parameter [2:0] SILICON_REVISION = 3'h1, // Arbitrary value.
   parameter [27:0] NORMAL_AGE_US = `NORMAL_AGE_US,
   parameter [27:0] FAST_AGE_US = `FAST_AGE_PASS_US,
   parameter [15:0] EE_TIMEOUT = `EE_TIMEOUT_CYC,
   parameter PORTS = 3
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire mode_strap_high_i,
   input wire mode_strap_low_i,
   output reg ee_rd_o,
   output reg [7:0] ee_addr_o,
   input wire ee_valid_i,
   input wire ee_nack_i,
   input wire [7:0] ee_data_i,
   input wire [PORTS-1:0] link_up_i,
   output reg switch_run_o,
   output reg new_backoff_o,
   output reg pass_flow_ctrl_o,
   output reg flush_table_o,
   output wire age_pass_o,
   output wire fast_age_o
);

   // ----------------------------------------------------------------
   // State encodings
   // ----------------------------------------------------------------
   localparam [3:0] LD_IDLE = 4'h1;
   localparam [3:0] LD_REQ = 4'h2;
   localparam [3:0] LD_WAIT = 4'h4;
   localparam [3:0] LD_DONE = 4'h8;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg [1:0] strap_m_q;
   reg [1:0] strap_s_q;
   reg [1:0] strap_q;
   reg strap_taken_q;
   reg [PORTS-1:0] link_m_q;
   reg [PORTS-1:0] link_s_q;
   reg [PORTS-1:0] link_d1_q;
   reg start_q;
   reg new_backoff_q;
   reg pass_flow_q;
   reg rsvd2_q;
   reg rsvd1_q;
   reg link_age_q;
   reg [3:0] ld_state_q;
   reg [1:0] ld_idx_q;
   reg [15:0] ld_timer_q;
   reg load_done_q;
   reg fast_req_q;
   wire [7:0] gc0_view;
   wire link_drop;
   wire managed;

   // Current global control 0 as seen by software.
   assign gc0_view = {new_backoff_q, `GC0_FIXED_6_4, pass_flow_q,
                      rsvd2_q, rsvd1_q, link_age_q};
   assign managed = strap_taken_q & (strap_q != 2'h0);
   assign link_drop = |(link_d1_q & ~link_s_q);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Straps and link status come from pins; two flops before use. The
   // strap pair keeps sampling in reset so the capture sees real pins.
   always @(posedge clk_i) begin
      strap_m_q <= {mode_strap_high_i, mode_strap_low_i};
      strap_s_q <= strap_m_q;
      if (!rst_n_i) begin
         link_m_q <= {PORTS{1'b0}};
         link_s_q <= {PORTS{1'b0}};
         link_d1_q <= {PORTS{1'b0}};
      end else begin
         link_m_q <= link_up_i;
         link_s_q <= link_m_q;
         link_d1_q <= link_s_q;
      end
   end

   // Straps are caught once, two cycles after reset release, when the
   // synchroniser holds a real sample; later pin changes are ignored.
   reg strap_wait_q;
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         strap_q <= 2'h0;
         strap_taken_q <= 1'b0;
         strap_wait_q <= 1'b0;
      end else begin
         strap_wait_q <= 1'b1;
         if (strap_wait_q && !strap_taken_q) begin
            strap_q <= strap_s_q;
            strap_taken_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration memory loader
   // ----------------------------------------------------------------
   // Reads family, part and control bytes in that order. A nack or a
   // timeout means no memory, which leaves the defaults in place.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         ld_state_q <= LD_IDLE;
         ld_idx_q <= 2'h0;
         ld_timer_q <= 16'h0000;
         load_done_q <= 1'b0;
         ee_rd_o <= 1'b0;
         ee_addr_o <= 8'h00;
      end else begin
         ee_rd_o <= 1'b0;
         case (ld_state_q)
            LD_IDLE: begin
               if (strap_taken_q) begin
                  if (strap_q == 2'h0) begin
                     ld_state_q <= LD_REQ;
                     ld_idx_q <= 2'h0;
                  end else begin
                     ld_state_q <= LD_DONE;
                  end
               end
            end
            LD_REQ: begin
               ee_rd_o <= 1'b1;
               ee_addr_o <= (ld_idx_q == 2'h0) ? `EE_ADDR_FAMILY :
                            (ld_idx_q == 2'h1) ? `EE_ADDR_PART :
                            `EE_ADDR_GC0;
               ld_timer_q <= 16'h0000;
               ld_state_q <= LD_WAIT;
            end
            LD_WAIT: begin
               ld_timer_q <= ld_timer_q + 16'h0001;
               if (ee_nack_i || ld_timer_q == EE_TIMEOUT - 16'h0001) begin
                  ld_state_q <= LD_DONE; // (R4)
               end else if (ee_valid_i) begin
                  if (ld_idx_q == 2'h0 && ee_data_i != PRODUCT_LINE) begin
                     ld_state_q <= LD_DONE; // (R5)
                  end else if (ld_idx_q == 2'h1 &&
                               ee_data_i[7:4] != PART_CODE) begin
                     ld_state_q <= LD_DONE; // (R5)
                  end else if (ld_idx_q == 2'h2) begin
                     ld_state_q <= LD_DONE;
                  end else begin
                     ld_idx_q <= ld_idx_q + 2'h1;
                     ld_state_q <= LD_REQ;
                  end
               end
            end
            LD_DONE: begin
               load_done_q <= 1'b1;
            end
            default: begin
               ld_state_q <= LD_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Writable control registers
   // ----------------------------------------------------------------
   // The memory copy of control 0 lands only after both codes matched,
   // because the loader reaches byte two only then. Offset zero and the
   // code bits of offset one have no storage, so writes there vanish.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         start_q <= `RST_START; // (R1)
         new_backoff_q <= `RST_NEW_BACKOFF;
         pass_flow_q <= `RST_PASS_FLOW;
         rsvd2_q <= `RST_RSVD2;
         rsvd1_q <= `RST_RSVD1;
         link_age_q <= `RST_LINK_AGE;
      end else if (ld_state_q == LD_WAIT && ee_valid_i && !ee_nack_i &&
                   ld_idx_q == 2'h2) begin
         new_backoff_q <= ee_data_i[`BIT_NEW_BACKOFF]; // (R5)
         pass_flow_q <= ee_data_i[`BIT_PASS_FLOW];
         rsvd2_q <= ee_data_i[`BIT_RSVD2];
         rsvd1_q <= ee_data_i[`BIT_RSVD1];
         link_age_q <= ee_data_i[`BIT_LINK_AGE];
      end else if (wr_i) begin
         if (addr_i == `OFS_PART_START) begin
            start_q <= wdata_i[`BIT_START]; // (R12)
         end
         if (addr_i == `OFS_GLOBAL_CTRL0) begin
            new_backoff_q <= wdata_i[`BIT_NEW_BACKOFF]; // (R7)
            pass_flow_q <= wdata_i[`BIT_PASS_FLOW]; // (R8)
            rsvd2_q <= wdata_i[`BIT_RSVD2];
            rsvd1_q <= wdata_i[`BIT_RSVD1];
            link_age_q <= wdata_i[`BIT_LINK_AGE];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Data appear the cycle after the strobe and only then; unmapped
   // offsets read zero.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            `OFS_PRODUCT_LINE: rdata_o <= PRODUCT_LINE; // (R6)
            `OFS_PART_START: begin
               rdata_o <= {PART_CODE, SILICON_REVISION, start_q}; // (R6)
            end
            `OFS_GLOBAL_CTRL0: rdata_o <= gc0_view;
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Run gating and control outputs
   // ----------------------------------------------------------------
   // Nothing runs until the straps are known, so a managed part never
   // starts for even a cycle on the strap-00 path or the reverse.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         switch_run_o <= 1'b0;
         new_backoff_o <= 1'b0;
         pass_flow_ctrl_o <= 1'b0;
      end else begin
         if (managed) begin
            switch_run_o <= start_q; // (R1) (R2)
         end else begin
            switch_run_o <= load_done_q; // (R3)
         end
         new_backoff_o <= new_backoff_q; // (R7)
         pass_flow_ctrl_o <= pass_flow_q; // (R8)
      end
   end

   // ----------------------------------------------------------------
   // Link drop handling
   // ----------------------------------------------------------------
   // A flush runs on every drop; the fast pass only with aging enabled.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         flush_table_o <= 1'b0;
         fast_req_q <= 1'b0;
      end else begin
         flush_table_o <= link_drop; // (R10)
         fast_req_q <= link_drop & link_age_q; // (R9)
      end
   end

   age_pacer #(
      .US_CYC(`US_CYCLES),
      .NORMAL_US(NORMAL_AGE_US),
      .FAST_US(FAST_AGE_US)
   ) u_age_pacer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .fast_req_i(fast_req_q),
      .age_pass_o(age_pass_o),
      .fast_active_o(fast_age_o)
   );

endmodule // switch_global_start_ctrl

// [tb/sgsc_asserts.sv]
// Checker for the global start and control register block.
`timescale 1ns/100ps

module sgsc_asserts #(
   parameter [7:0] PRODUCT_LINE = 8'h5A,
   parameter [3:0] PART_CODE = 4'h5,
   parameter [2:0] SILICON_REVISION = 3'h1,
   parameter [27:0] FAST_AGE_US = 28'h5,
   parameter PORTS = 3
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire mode_strap_high_i,
   input wire mode_strap_low_i,
   input wire [PORTS-1:0] link_up_i,
   input wire switch_run_o,
   input wire new_backoff_o,
   input wire pass_flow_ctrl_o,
   input wire flush_table_o,
   input wire age_pass_o,
   input wire fast_age_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // A 1 us tick of arbitrary phase may cut the pass short by up to one tick.
   localparam int FAST_MAX = FAST_AGE_US * 200 + 4;
   wire managed = mode_strap_high_i | mode_strap_low_i;
   reg [19:0] fast_cnt_q;
   // ----------------------------------------------------------------
   // Fast aging length counter.
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      fast_cnt_q <= (rst_n_i && fast_age_o) ? fast_cnt_q + 20'h1 : 20'h0;
   end
   sequence drop_s;
      |(~link_up_i & $past(link_up_i));
   endsequence
   sequence flush_s;
      ##[2:6] flush_table_o;
   endsequence
   a_read_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not idle");
   a_family_fixed: assert property (rd_i && addr_i == 8'h00 |=>
      rdata_o == PRODUCT_LINE) else $error("family code wrong");
   a_part_fixed: assert property (rd_i && addr_i == 8'h01 |=>
      rdata_o[7:1] == {PART_CODE, SILICON_REVISION})
      else $error("part code wrong");
   a_ctrl_fixed_bits: assert property (rd_i && addr_i == 8'h02 |=>
      rdata_o[6:4] == 3'h4) else $error("fixed bits wrong");
   a_backoff_follows: assert property (wr_i && addr_i == 8'h02
      ##1 !wr_i |=> new_backoff_o == $past(wdata_i[7], 2))
      else $error("back-off select wrong");
   a_pass_flow_follows: assert property (wr_i && addr_i == 8'h02
      ##1 !wr_i |=> pass_flow_ctrl_o == $past(wdata_i[3], 2))
      else $error("flow pass select wrong");
   a_start_runs: assert property (wr_i && addr_i == 8'h01 &&
      wdata_i[0] && managed |-> ##[1:4] switch_run_o)
      else $error("switch did not start");
   a_stop_holds: assert property (wr_i && addr_i == 8'h01 &&
      !wdata_i[0] && managed |-> ##[1:4] !switch_run_o)
      else $error("switch did not stop");
   a_drop_flushes: assert property (drop_s |-> flush_s)
      else $error("no flush on link drop");
   a_fast_after_flush: assert property ($rose(fast_age_o) |->
      $past(flush_table_o)) else $error("fast aging without drop");
   a_fast_bounded: assert property (fast_cnt_q <= FAST_MAX)
      else $error("fast aging too long");
   a_fast_ends_pass: assert property ($fell(fast_age_o) |->
      age_pass_o || $past(age_pass_o)) else $error("no pass at end");
endmodule // sgsc_asserts

bind switch_global_start_ctrl sgsc_asserts #(
   .PRODUCT_LINE(PRODUCT_LINE), .PART_CODE(PART_CODE),
   .SILICON_REVISION(SILICON_REVISION), .FAST_AGE_US(FAST_AGE_US),
   .PORTS(PORTS)) sgsc_asserts_inst (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .mode_strap_high_i(mode_strap_high_i),
   .mode_strap_low_i(mode_strap_low_i), .link_up_i(link_up_i),
   .switch_run_o(switch_run_o), .new_backoff_o(new_backoff_o),
   .pass_flow_ctrl_o(pass_flow_ctrl_o), .flush_table_o(flush_table_o),
   .age_pass_o(age_pass_o), .fast_age_o(fast_age_o));

// [tb/ee_model.sv]
// Behavioural configuration memory answering byte read requests.
`timescale 1ns/100ps

module ee_model #(
   parameter [7:0] FAMILY = 8'h5A, // Arbitrary value.
   parameter [3:0] PART = 4'h5, // Arbitrary value.
   parameter [7:0] GC0 = 8'h8C
) (
   input wire clk_i,
   input wire ee_rd_i,
   input wire [7:0] ee_addr_i,
   input wire [1:0] mode_i, // 0 good, 1 bad family, 2 nack, 3 silent.
   input wire [3:0] lat_i,
   output reg ee_valid_o,
   output reg ee_nack_o,
   output reg [7:0] ee_data_o
);
   reg busy_q = 1'b0;
   reg [3:0] wait_q = 4'h0;
   reg [7:0] byte_q = 8'h00;
   initial begin
      ee_valid_o = 1'b0;
      ee_nack_o = 1'b0;
      ee_data_o = 8'h00;
   end
   // ----------------------------------------------------------------
   // Answer after a latency; idle data toggles so stale bytes show.
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      ee_valid_o <= 1'b0;
      ee_nack_o <= 1'b0;
      ee_data_o <= ~ee_data_o;
      if (ee_rd_i) begin
         busy_q <= 1'b1;
         wait_q <= lat_i;
         case (ee_addr_i)
            8'h00: byte_q <= (mode_i == 2'h1) ? ~FAMILY : FAMILY;
            8'h01: byte_q <= {PART, 4'h3};
            default: byte_q <= GC0;
         endcase
      end else if (busy_q && wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
         busy_q <= 1'b0;
         ee_nack_o <= (mode_i == 2'h2);
         ee_valid_o <= (mode_i < 2'h2);
         if (mode_i < 2'h2) ee_data_o <= byte_q;
      end
   end
endmodule // ee_model

// [tb/test_switch_global_start_ctrl.sv]
// Testbench for the global start and control register block.
`timescale 1ns/100ps

module test_switch_global_start_ctrl;
   reg clk_i, rst_n_i, wr_i, rd_i, mode_strap_high_i, mode_strap_low_i;
   reg [7:0] addr_i, wdata_i;
   reg [2:0] link_up_i;
   reg [1:0] ee_mode;
   reg [3:0] ee_lat;
   wire [7:0] rdata_o, ee_addr_o, ee_data;
   wire ee_rd_o, ee_valid, ee_nack, switch_run_o, new_backoff_o;
   wire pass_flow_ctrl_o, flush_table_o, fast_age_o;
   int mismatches = 0;
   int n_tests = 0;
   int i, m;

   switch_global_start_ctrl #(.NORMAL_AGE_US(28'h32), .FAST_AGE_US(28'h5),
      .EE_TIMEOUT(16'h10)) switch_global_start_ctrl_inst (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .mode_strap_high_i(mode_strap_high_i),
      .mode_strap_low_i(mode_strap_low_i), .ee_rd_o(ee_rd_o),
      .ee_addr_o(ee_addr_o), .ee_valid_i(ee_valid), .ee_nack_i(ee_nack),
      .ee_data_i(ee_data), .link_up_i(link_up_i),
      .switch_run_o(switch_run_o), .new_backoff_o(new_backoff_o),
      .pass_flow_ctrl_o(pass_flow_ctrl_o), .flush_table_o(flush_table_o),
      .age_pass_o(), .fast_age_o(fast_age_o));

   ee_model ee_model_inst (.clk_i(clk_i), .ee_rd_i(ee_rd_o),
      .ee_addr_i(ee_addr_o), .mode_i(ee_mode), .lat_i(ee_lat),
      .ee_valid_o(ee_valid), .ee_nack_o(ee_nack), .ee_data_o(ee_data));

   // ----------------------------------------------------------------
   // Clock, helpers and bus tasks.
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Sampling 1 ns past the edge keeps checks clear of edge races.
   task tick;
      @(posedge clk_i);
      #1;
   endtask
   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask
   task boot(input [1:0] s);
      tick;
      rst_n_i <= 1'b0;
      {mode_strap_high_i, mode_strap_low_i} <= s;
      repeat (8) tick;
      rst_n_i <= 1'b1;
      repeat (2) tick;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      tick;
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      tick;
      wr_i <= 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] exp);
      tick;
      addr_i <= a;
      rd_i <= 1'b1;
      tick;
      rd_i <= 1'b0;
      chk("rdata", exp, rdata_o);
   endtask
   task drop(input [2:0] v, input logic fast);
      link_up_i <= v;
      for (i = 0; i < 8 && flush_table_o !== 1'b1; i++) tick;
      chk("flush", 8'h01, 8'(flush_table_o));
      repeat (2) tick;
      chk("fast_age", 8'(fast), 8'(fast_age_o));
   endtask
   task wrap_up;
      if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      {rst_n_i, wr_i, rd_i, mode_strap_high_i, mode_strap_low_i} = 5'h00;
      {addr_i, wdata_i} = 16'h0000;
      link_up_i = 3'h7;
      {ee_mode, ee_lat} = 6'h00;
      boot(2'h1);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h5A);
      rd(8'h01, 8'h53);
      rd(8'h02, 8'h44);
      repeat (6) tick;
      chk("run", 8'h01, 8'(switch_run_o));
      wr(8'h01, 8'hF0);
      rd(8'h01, 8'h52);
      repeat (4) tick;
      chk("run", 8'h00, 8'(switch_run_o));
      wr(8'h01, 8'h01);
      repeat (4) tick;
      chk("run", 8'h01, 8'(switch_run_o));
      wr(8'h02, 8'hCD);
      rd(8'h02, 8'hCD);
      chk("backoff", 8'h01, 8'(new_backoff_o));
      chk("pass_flow", 8'h01, 8'(pass_flow_ctrl_o));
      wr(8'h02, 8'h45);
      rd(8'h02, 8'h45);
      chk("pass_flow", 8'h00, 8'(pass_flow_ctrl_o));
      drop(3'h5, 1'b1);
      for (i = 0; i < 1300 && fast_age_o !== 1'b0; i++) tick;
      chk("fast_age", 8'h00, 8'(fast_age_o));
      wr(8'h02, 8'h44);
      link_up_i <= 3'h7;
      repeat (6) tick;
      drop(3'h6, 1'b0);
      // Unmanaged start for good, wrong, absent and silent memory.
      for (m = 0; m < 4; m++) begin
         ee_mode <= m[1:0];
         ee_lat <= {m[1:0], 2'h0};
         boot(2'h0);
         for (i = 0; i < 300 && switch_run_o !== 1'b1; i++) tick;
         chk("run", 8'h01, 8'(switch_run_o));
         rd(8'h02, (m == 0) ? 8'hCC : 8'h44);
         chk("backoff", 8'(m == 0), 8'(new_backoff_o));
      end
      wrap_up;
   end

   // Cuts a hang short well beyond the expected run of about 1200 cycles.
   initial begin
      repeat (40000) @(posedge clk_i);
      mismatches++;
      wrap_up;
   end
endmodule // test_switch_global_start_ctrl
